// >>> rtl/bps_top.sv
// Enhanced PWM output stage with APB register access.
// Assumes an APB master on sys_clk; outputs feed external bridge drivers.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module bps_top #(
    parameter int DB_W = 7
) (
    input  wire logic        sys_clk,   // 100 MHz clock
    input  wire logic        reset_n,   // Async reset, active low
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB enable
    input  wire logic        pwrite,    // APB write
    input  wire logic [7:0]  paddr,     // APB byte address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic      [31:0] prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error, unmapped address
    output logic      [3:0]  pin_out,   // Output levels, bit0 = A .. bit3 = D
    output logic      [3:0]  pin_drive  // High where the block owns the pin
);
    if (DB_W < 1 || DB_W > 8) begin : g_bad_db_w
        $error("DB_W must be 1 to 8");
    end

    // Registers
    logic [7:0]      ctrl_ff;
    logic [7:0]      duty_hi_ff;
    logic [9:0]      duty_buf_ff;
    logic [7:0]      period_ff;
    logic [DB_W-1:0] db_cnt_ff;
    logic [2:0]      tmr_ctl_ff;
    logic [7:0]      timer_ff;
    logic [5:0]      pre_cnt_ff;
    logic            raw_ff;
    logic [1:0]      cfg_ff;
    logic [1:0]      pol_ff;
    logic            run_ff;
    logic [3:0]      act_ff;
    logic [3:0]      pin_out_ff;
    logic [3:0]      pin_drive_ff;
    logic [31:0]     prdata_ff;
    logic            pready_ff;
    logic            pslverr_ff;

    // APB decode
    wire        setup    = psel & ~penable;
    wire        wr_acc   = psel & penable & pwrite & pready_ff;
    wire        hit_ctrl = (paddr == bps_pkg::OFF_CTRL);
    wire        hit_dhi  = (paddr == bps_pkg::OFF_DUTY_HI);
    wire        hit_act  = (paddr == bps_pkg::OFF_ACT_DUTY);
    wire        hit_per  = (paddr == bps_pkg::OFF_PERIOD);
    wire        hit_db   = (paddr == bps_pkg::OFF_DEADBAND);
    wire        hit_tmr  = (paddr == bps_pkg::OFF_TMR_CTL);
    wire        hit_sts  = (paddr == bps_pkg::OFF_STATUS);
    wire        hit_any  = hit_ctrl | hit_dhi | hit_act | hit_per | hit_db | hit_tmr | hit_sts;
    wire        pwm_sel  = (ctrl_ff[3:2] == bps_pkg::MODE_PWM);
    wire [9:0]  duty_new = {duty_hi_ff, ctrl_ff[bps_pkg::CTRL_DLSB_LSB +: 2]};
    logic [31:0] rd_data;

    always_comb begin
        if (hit_ctrl) begin
            rd_data = {24'h0, ctrl_ff};
        end else if (hit_dhi) begin
            rd_data = {24'h0, duty_hi_ff};
        end else if (hit_act) begin
            rd_data = {24'h0, duty_buf_ff[9:2]};
        end else if (hit_per) begin
            rd_data = {24'h0, period_ff};
        end else if (hit_db) begin
            rd_data = {{(32-DB_W){1'b0}}, db_cnt_ff};
        end else if (hit_tmr) begin
            rd_data = {29'h0, tmr_ctl_ff};
        end else if (hit_sts) begin
            rd_data = {16'h0, pin_out_ff, pin_drive_ff, timer_ff};
        end else begin
            rd_data = 32'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_ff  <= 32'h0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            if (setup) begin
                prdata_ff  <= rd_data;
                pslverr_ff <= ~hit_any;
            end
        end
    end

    // Prescaler and timer; one timer step every 4 Tosc times the prescale
    wire [1:0] pre_sel  = tmr_ctl_ff[1:0];
    wire       tmr_on   = tmr_ctl_ff[bps_pkg::TMR_ON_BIT];
    wire [5:0] pre_max  = (pre_sel == bps_pkg::PRE_DIV1) ? 6'h03 :
                          (pre_sel == bps_pkg::PRE_DIV4) ? 6'h0f : 6'h3f;
    wire [3:0] low_mask = (pre_sel == bps_pkg::PRE_DIV1) ? 4'h0 :
                          (pre_sel == bps_pkg::PRE_DIV4) ? 4'h3 : 4'hf;
    wire [1:0] fine     = (pre_sel == bps_pkg::PRE_DIV1) ? pre_cnt_ff[1:0] :
                          (pre_sel == bps_pkg::PRE_DIV4) ? pre_cnt_ff[3:2] : pre_cnt_ff[5:4];
    wire       tick       = tmr_on & (pre_cnt_ff == pre_max);
    wire       period_end = tick & (timer_ff == period_ff);
    wire       step_end   = tmr_on & ((pre_cnt_ff[3:0] & low_mask) == low_mask);
    wire       instr_en   = tmr_on & (pre_cnt_ff[1:0] == 2'h3);
    // Position reaches duty on the next step; duty past the period never matches
    wire [9:0] pos        = {timer_ff, fine};
    wire       duty_hit   = step_end & (duty_buf_ff != 10'h0)
                            & (pos == duty_buf_ff - 10'h001);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt_ff <= 6'h0;
            timer_ff   <= 8'h0;
        end else begin
            if (!tmr_on || tick) begin
                pre_cnt_ff <= 6'h0;
            end else begin
                pre_cnt_ff <= pre_cnt_ff + 6'h01;
            end
            if (period_end) begin
                timer_ff <= 8'h0;
            end else if (tick) begin
                timer_ff <= timer_ff + 8'h01;
            end
        end
    end

    // Software registers and the double-buffered duty
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff     <= bps_pkg::CTRL_RST;
            duty_hi_ff  <= bps_pkg::DUTY_HI_RST;
            period_ff   <= bps_pkg::PERIOD_RST;
            db_cnt_ff   <= DB_W'(bps_pkg::DEADBAND_RST);
            tmr_ctl_ff  <= bps_pkg::TMR_CTL_RST;
            duty_buf_ff <= 10'h0;
        end else begin
            if (wr_acc && hit_ctrl) ctrl_ff <= pwdata[7:0];
            if (wr_acc && hit_dhi) duty_hi_ff <= pwdata[7:0];
            if (wr_acc && hit_per) period_ff <= pwdata[7:0];
            if (wr_acc && hit_db) db_cnt_ff <= pwdata[DB_W-1:0];
            if (wr_acc && hit_tmr) tmr_ctl_ff <= pwdata[2:0];
            if (period_end) begin
                duty_buf_ff <= duty_new;
            end else if (wr_acc && hit_act && !pwm_sel) begin
                duty_buf_ff <= {pwdata[7:0], duty_buf_ff[1:0]};
            end
        end
    end

    // Modulated waveform: high from the boundary until the duty position
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            raw_ff <= 1'b0;
        end else if (!pwm_sel) begin
            raw_ff <= 1'b0;
        end else if (period_end) begin
            raw_ff <= (duty_new != 10'h0);
        end else if (duty_hit) begin
            raw_ff <= 1'b0;
        end
    end

    // Config and polarity take effect at a boundary, or at once outside PWM mode, to avoid glitches
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_ff <= 2'h0;
            pol_ff <= 2'h0;
            run_ff <= 1'b0;
        end else begin
            run_ff <= pwm_sel;
            if (period_end || !pwm_sel) begin
                cfg_ff <= ctrl_ff[bps_pkg::CTRL_CFG_LSB +: 2];
                pol_ff <= ctrl_ff[1:0];
            end
        end
    end

    // Dead-band only in half-bridge; other configs pass with zero delay
    wire            is_half = (cfg_ff == bps_pkg::CFG_HALF);
    wire [DB_W-1:0] dly     = is_half ? db_cnt_ff : '0;
    wire [1:0]      db_in   = {~raw_ff & run_ff, raw_ff};
    wire [1:0]      db_out;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_db
            bps_deadband #(.W(DB_W)) u_db (
                .sys_clk  (sys_clk),
                .reset_n  (reset_n),
                .instr_en (instr_en),
                .dly      (dly),
                .lvl_in   (db_in[i]),
                .lvl_out  (db_out[i])
            );
        end
    endgenerate

    // Steering: active levels {D,C,B,A} and which pins the block owns
    logic [3:0] nxt_act;
    logic [3:0] nxt_drive;
    always_comb begin
        nxt_act   = 4'h0;
        nxt_drive = 4'h0;
        if (run_ff) begin
            case (cfg_ff)
                bps_pkg::CFG_SINGLE: begin
                    nxt_act   = {3'h0, db_out[0]};
                    nxt_drive = 4'h1;
                end
                bps_pkg::CFG_HALF: begin
                    nxt_act   = {2'h0, db_out[1], db_out[0]};
                    nxt_drive = 4'h3;
                end
                bps_pkg::CFG_FULL_FWD: begin
                    nxt_act   = {db_out[0], 2'h0, 1'b1};
                    nxt_drive = 4'hf;
                end
                default: begin
                    nxt_act   = {2'h0, db_out[0], 1'b0} | 4'h4;
                    nxt_drive = 4'hf;
                end
            endcase
        end
    end

    // Bit 1 of the mode makes A,C active-low; bit 0 makes B,D active-low
    wire [3:0] pol_vec = run_ff ? {pol_ff[0], pol_ff[1], pol_ff[0], pol_ff[1]} : 4'h0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            act_ff       <= 4'h0;
            pin_out_ff   <= 4'h0;
            pin_drive_ff <= 4'h0;
        end else begin
            act_ff       <= nxt_act;
            pin_out_ff   <= nxt_act ^ pol_vec;
            pin_drive_ff <= nxt_drive;
        end
    end

    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign pin_out   = pin_out_ff;
    assign pin_drive = pin_drive_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_duty_load: assert property (period_end |=> duty_buf_ff == $past(duty_new))
        else $error("duty buffer not loaded at period end");
    a_timer_clear: assert property (period_end |=> timer_ff == 8'h0)
        else $error("timer not cleared at period end");
    a_zero_duty: assert property (period_end && duty_new == 10'h0 |=> !raw_ff)
        else $error("output set with zero duty");
    a_set_start: assert property (pwm_sel && period_end && duty_new != 10'h0 |=> raw_ff)
        else $error("output not set at period start");
    a_buffer_ro: assert property (pwm_sel && !period_end |=> $stable(duty_buf_ff))
        else $error("active duty buffer changed in PWM mode");
    a_long_duty: assert property (raw_ff && pwm_sel && !period_end
                                  && duty_buf_ff > {period_ff, 2'h3} |=> raw_ff)
        else $error("output cleared with duty beyond period");
    a_tick_gap: assert property (tick |=> !tick [*3])
        else $error("timer stepped faster than 4 Tosc");
    a_full_two: assert property (cfg_ff[0] && run_ff |=> $countones(act_ff) <= 2)
        else $error("more than two full-bridge outputs active");
    a_fwd_steer: assert property (cfg_ff == bps_pkg::CFG_FULL_FWD && run_ff
                                  |=> act_ff[0] && !act_ff[1] && !act_ff[2])
        else $error("forward steering wrong");
    a_rev_steer: assert property (cfg_ff == bps_pkg::CFG_FULL_REV && run_ff
                                  |=> act_ff[2] && !act_ff[0] && !act_ff[3])
        else $error("reverse steering wrong");
    a_half_excl: assert property (is_half && run_ff |=> !(act_ff[0] && act_ff[1]))
        else $error("half-bridge outputs both active");
    a_cfg_hold: assert property (pwm_sel && run_ff && !period_end |=> $stable(cfg_ff))
        else $error("config changed mid-period");

    c_half_run: cover property (is_half && run_ff && act_ff[1] ##1 act_ff[0]);
    c_full_fwd: cover property (cfg_ff == bps_pkg::CFG_FULL_FWD && act_ff[3]);
    c_zero_duty: cover property (period_end && pwm_sel && duty_new == 10'h0);
    c_duty_clear: cover property (raw_ff && duty_hit);
endmodule

// >>> rtl/bps_pkg.sv
// Constants for the bridge PWM output steering block.
// Assumes a 100 MHz system clock acting as the oscillator period.
package bps_pkg;

    // Register byte offsets on the APB slave
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_DUTY_HI  = 8'h04;
    localparam logic [7:0] OFF_ACT_DUTY = 8'h08;
    localparam logic [7:0] OFF_PERIOD   = 8'h0c;
    localparam logic [7:0] OFF_DEADBAND = 8'h10;
    localparam logic [7:0] OFF_TMR_CTL  = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;

    // Field positions of pwm_control_reg and of the timer control register (TMR_ON_BIT)
    localparam int CTRL_CFG_LSB  = 6;
    localparam int CTRL_DLSB_LSB = 4;
    localparam int TMR_ON_BIT    = 2;

    // Reset values
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [7:0] DUTY_HI_RST  = 8'h00;
    localparam logic [7:0] PERIOD_RST   = 8'hff;
    localparam logic [6:0] DEADBAND_RST = 7'h00;
    localparam logic [2:0] TMR_CTL_RST  = 3'h0;

    // Unit mode upper bits that select PWM operation
    localparam logic [1:0] MODE_PWM = 2'h3;

    // Timing: oscillator periods per instruction cycle
    localparam int TOSC_PER_INSTR = 4;

    // Prescaler selections
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;

    typedef enum logic [1:0] {
        CFG_SINGLE   = 2'b00,
        CFG_FULL_FWD = 2'b01,
        CFG_HALF     = 2'b10,
        CFG_FULL_REV = 2'b11
    } bps_cfg_e;

endpackage

// >>> rtl/bps_deadband.sv
// Dead-band delay stage: delays a rising level by a count of
// instruction cycles after the first instruction pulse; falling edges pass
// with one clock of latency.
// Assumes instr_en is a one-cycle pulse every instruction cycle.
`timescale 1ns/1ps
module bps_deadband #(
    parameter int W = 7
) (
    input  wire logic         sys_clk,  // System clock
    input  wire logic         reset_n,  // Async reset, active low
    input  wire logic         instr_en, // Instruction cycle pulse
    input  wire logic [W-1:0] dly,      // Delay in instruction cycles
    input  wire logic         lvl_in,   // Undelayed active level
    output logic              lvl_out   // Delayed active level
);
    logic         prev_ff;
    logic [W:0]   cnt_ff;
    logic         out_ff;
    wire          rise    = lvl_in & ~prev_ff;
    wire  [W:0]   cnt_inc = cnt_ff + {{W{1'b0}}, 1'b1};
    // First pulse only aligns to the instruction cycle, so the delay is never short
    wire  [W:0]   cnt_end = {1'b0, dly} + {{W{1'b0}}, 1'b1};

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_ff <= 1'b0;
            cnt_ff  <= '0;
            out_ff  <= 1'b0;
        end else begin
            prev_ff <= lvl_in;
            if (!lvl_in) begin
                // A drop before the count ends keeps the output low all cycle
                cnt_ff <= '0;
                out_ff <= 1'b0;
            end else if (rise) begin
                cnt_ff <= '0;
                out_ff <= (dly == '0);
            end else if (!out_ff && instr_en) begin
                cnt_ff <= cnt_inc;
                // At or past the end, so a delay shortened mid-count cannot stall
                out_ff <= (cnt_inc >= cnt_end);
            end
        end
    end

    assign lvl_out = out_ff;
endmodule

// >>> dv/bps_bridge_drv.sv
// Bridge switch driver model: counts how long each power switch is on.
// Assumes undriven block pins hold their switches off at the driver inputs.
`timescale 1ns/1ps
module bps_bridge_drv (
    input  wire logic             sys_clk,   // System clock
    input  wire logic             reset_n,   // Async reset, active low
    input  wire logic [3:0]       pin_out,   // Levels from the block
    input  wire logic [3:0]       pin_drive, // High where the block drives
    input  wire logic [3:0]       pol_low,   // Switches wired active low
    input  wire logic             clr,       // Restart the counts
    output logic      [3:0][15:0] on_cnt_ff, // On cycles per switch
    output logic      [15:0]      shoot_ff,  // Cycles with A and B both on
    output logic      [15:0]      over_ff    // Cycles with over two on
);
    logic [3:0] sw_on;
    logic [2:0] n_on;

    // A pin left to port control never turns its switch on
    assign sw_on = pin_drive & (pin_out ^ pol_low);
    assign n_on  = 3'(sw_on[0]) + 3'(sw_on[1]) + 3'(sw_on[2]) + 3'(sw_on[3]);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            on_cnt_ff <= '0;
            shoot_ff  <= '0;
            over_ff   <= '0;
        end else if (clr) begin
            on_cnt_ff <= '0;
            shoot_ff  <= '0;
            over_ff   <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                on_cnt_ff[i] <= on_cnt_ff[i] + 16'(sw_on[i]);
            end
            // Shoot-through: both half-bridge switches on together
            shoot_ff <= shoot_ff + 16'(sw_on[0] & sw_on[1]);
            over_ff  <= over_ff + 16'(n_on > 3'h2);
        end
    end
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the bridge PWM output stage.
// Assumes the block answers APB and drives the bridge driver model.
`timescale 1ns/1ps
module testbench;
    logic             sys_clk;
    logic             reset_n;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [7:0]       paddr;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [3:0]       pin_out;
    logic [3:0]       pin_drive;
    logic [3:0]       pol_low;
    logic             clr;
    logic [3:0][15:0] on_cnt;
    logic [15:0]      shoot_cnt;
    logic [15:0]      over_cnt;
    logic [31:0]      rd;
    logic             err;
    int               num_errors = 0;
    int               checks = 0;

    bps_top #(.DB_W(7)) bps_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_drive(pin_drive));
    bps_bridge_drv bps_bridge_drv_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .pin_out(pin_out), .pin_drive(pin_drive), .pol_low(pol_low), .clr(clr),
        .on_cnt_ff(on_cnt), .shoot_ff(shoot_cnt), .over_ff(over_cnt));

    always #5 sys_clk = ~sys_clk;

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input int lo, input int hi, input logic [31:0] got);
        checks++;
        if (($signed({1'b0, got}) >= lo && $signed({1'b0, got}) <= hi) !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %s expected %0d..%0d seen %0h", what, lo, hi, got);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        if (n >= 50) begin
            num_errors++;
            $display("[FAIL] apb ready expected 1 seen timeout");
            summarize();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, exp, rd);
    endtask

    // Settle two windows, then count switch on-time over one window
    task automatic run_case(input string name, input logic [7:0] ctrl, input logic [3:0] drv,
                            input int win, input int lo[4], input int hi[4]);
        apb(1'b1, bps_pkg::OFF_CTRL, {24'h0, ctrl});
        pol_low <= {ctrl[0], ctrl[1], ctrl[0], ctrl[1]};
        repeat (2 * win) @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (win) @(posedge sys_clk);
        #1;
        chk("pin_drive", drv, drv, pin_drive);
        for (int i = 0; i < 4; i++) begin
            chk("switch on cycles", lo[i], hi[i], on_cnt[i]);
        end
        chk("shoot through", 0, 0, shoot_cnt);
        chk("over two on", 0, 0, over_cnt);
        $display("case %s done", name);
    endtask

    task automatic test_regs;
        rdc("ctrl", bps_pkg::OFF_CTRL, 0);
        rdc("duty high", bps_pkg::OFF_DUTY_HI, 0);
        rdc("active duty", bps_pkg::OFF_ACT_DUTY, 0);
        rdc("period", bps_pkg::OFF_PERIOD, 255);
        rdc("deadband", bps_pkg::OFF_DEADBAND, 0);
        rdc("timer ctl", bps_pkg::OFF_TMR_CTL, 0);
        rdc("unmapped", 8'h20, 0);
        chk("unmapped error", 1, 1, err);
        $display("test regs done");
    endtask

    task automatic test_buffer;
        apb(1'b1, bps_pkg::OFF_PERIOD, 32'h3);
        apb(1'b1, bps_pkg::OFF_DUTY_HI, 32'h1);
        apb(1'b1, bps_pkg::OFF_CTRL, 32'h2c);
        apb(1'b1, bps_pkg::OFF_ACT_DUTY, 32'h55);
        rdc("active duty held", bps_pkg::OFF_ACT_DUTY, 0);
        apb(1'b1, bps_pkg::OFF_TMR_CTL, 32'h4);
        repeat (40) @(posedge sys_clk);
        rdc("active duty loaded", bps_pkg::OFF_ACT_DUTY, 1);
        apb(1'b1, bps_pkg::OFF_ACT_DUTY, 32'h77);
        rdc("active duty read only", bps_pkg::OFF_ACT_DUTY, 1);
        $display("test buffer done");
    endtask

    // Duty {8'h01, 2'b10} = 6, period (3+1)*4 = 16 clocks per prescale step
    task automatic test_single;
        int f;
        for (int p = 0; p < 3; p++) begin
            f = (p == 0) ? 1 : (p == 1) ? 4 : 16;
            apb(1'b1, bps_pkg::OFF_TMR_CTL, 32'(4 + p));
            run_case("single", 8'h2c, 4'h1, 32 * f,
                     '{12 * f, 0, 0, 0}, '{12 * f, 0, 0, 0});
        end
        apb(1'b1, bps_pkg::OFF_TMR_CTL, 32'h4);
        // Prescale counter may run past the new limit and wrap first
        repeat (80) @(posedge sys_clk);
        $display("test single done");
    endtask

    task automatic test_extremes;
        apb(1'b1, bps_pkg::OFF_DUTY_HI, 32'h0);
        run_case("zero duty", 8'h0c, 4'h1, 32, '{0, 0, 0, 0}, '{0, 0, 0, 0});
        apb(1'b1, bps_pkg::OFF_DUTY_HI, 32'hff);
        run_case("long duty", 8'h3c, 4'h1, 32, '{32, 0, 0, 0}, '{32, 0, 0, 0});
        $display("test extremes done");
    endtask

    // Period 32 clocks, duty 16: each side loses 4..7 clocks per dead band unit
    task automatic test_half;
        apb(1'b1, bps_pkg::OFF_PERIOD, 32'h7);
        apb(1'b1, bps_pkg::OFF_DUTY_HI, 32'h4);
        apb(1'b1, bps_pkg::OFF_DEADBAND, 32'h1);
        run_case("half", 8'h8c, 4'h3, 64, '{18, 18, 0, 0}, '{24, 24, 0, 0});
        run_case("half low", 8'h8f, 4'h3, 64, '{18, 18, 0, 0}, '{24, 24, 0, 0});
        apb(1'b1, bps_pkg::OFF_DEADBAND, 32'h5);
        run_case("half long band", 8'h8c, 4'h3, 64, '{0, 0, 0, 0}, '{0, 0, 0, 0});
        $display("test half done");
    endtask

    // Period kept at 32 clocks: lowering it under the timer would wrap the timer
    task automatic test_full;
        apb(1'b1, bps_pkg::OFF_DUTY_HI, 32'h1);
        for (int m = 0; m < 4; m++) begin
            run_case("forward", 8'h6c | 8'(m), 4'hf, 32,
                     '{32, 0, 0, 6}, '{32, 0, 0, 6});
            run_case("reverse", 8'hec | 8'(m), 4'hf, 32,
                     '{0, 6, 32, 0}, '{0, 6, 32, 0});
        end
        $display("test full done");
    endtask

    task automatic test_exit;
        apb(1'b1, bps_pkg::OFF_CTRL, 32'h0);
        repeat (3) @(posedge sys_clk);
        #1;
        chk("pin_drive off", 0, 0, pin_drive);
        chk("pin_out off", 0, 0, pin_out);
        $display("test exit done");
    endtask

    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h0;
        pwdata  = 32'h0;
        pol_low = 4'h0;
        clr     = 1'b0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        test_regs();
        test_buffer();
        test_single();
        test_extremes();
        test_half();
        test_full();
        test_exit();
        summarize();
    end
endmodule
